//--- rsf_pkg.sv
// Package for the reset source and flag unit.
// Assumes one 10 MHz clock and a classic Wishbone register port.
package rsf_pkg;
   // ==========================================================
   // Register map
   localparam logic [3:0]  RSF_ADDR_RCC     = 4'h0;
   localparam logic [15:0] RSF_RCC_RESET    = 16'h0003;
   localparam logic [15:0] RSF_RCC_IMPL     = 16'hE7FF;
   // ==========================================================
   // Field positions
   localparam int RSF_B_TRAP   = 15;
   localparam int RSF_B_ILL    = 14;
   localparam int RSF_B_SBOR   = 13;
   localparam int RSF_B_DSLP   = 10;
   localparam int RSF_B_CFGM   = 9;
   localparam int RSF_B_PROGMEM_SLEEP_POWER  = 8;
   localparam int RSF_B_PIN    = 7;
   localparam int RSF_B_SWR    = 6;
   localparam int RSF_B_SWDT   = 5;
   localparam int RSF_B_WATCHDOG_TIMEOUT_FLAG   = 4;
   localparam int RSF_B_SLEEP  = 3;
   localparam int RSF_B_IDLE   = 2;
   localparam int RSF_B_BOR    = 1;
   localparam int RSF_B_POR    = 0;
   // ==========================================================
   // Reset source bundle
   typedef struct packed {
      logic trap_conflict;
      logic illegal_opcode;
      logic uninit_wreg_reset;
      logic config_mismatch;
      logic master_clear_pin;
      logic reset_instr;
      logic watchdog_reset_source;
      logic brownout;
      logic lp_brownout;
   } rsf_src_t;
   // Power-saving events
   typedef struct packed {
      logic deep_sleep;
      logic sleep;
      logic idle;
   } rsf_pwr_t;
   typedef enum logic [1:0] {
      RSF_BUS_IDLE = 2'b00,
      RSF_BUS_ACK  = 2'b01
   } rsf_bus_st_t;
endpackage : rsf_pkg

//--- rsf_combiner.sv
// Combines every reset source into one request and a flag set vector.
// Assumes sources are synchronous single-clock levels.
`timescale 1ns/1ps
`default_nettype none
module rsf_combiner
   import rsf_pkg::*;
(
   input  wire logic        por_i,
   input  wire rsf_src_t    src_i,
   input  wire rsf_pwr_t    pwr_i,
   output logic             any_reset_o,
   output logic [15:0]      set_vec_o
);
   // ==========================================================
   // Combine
   always_comb begin
      any_reset_o = por_i | (|src_i);
      set_vec_o                = 16'h0000;
      set_vec_o[RSF_B_TRAP]    = src_i.trap_conflict;
      set_vec_o[RSF_B_ILL]     = src_i.illegal_opcode | src_i.uninit_wreg_reset;
      set_vec_o[RSF_B_CFGM]    = src_i.config_mismatch;
      set_vec_o[RSF_B_PIN]     = src_i.master_clear_pin;
      set_vec_o[RSF_B_SWR]     = src_i.reset_instr;
      set_vec_o[RSF_B_WATCHDOG_TIMEOUT_FLAG]    = src_i.watchdog_reset_source;
      set_vec_o[RSF_B_BOR]     = src_i.brownout | src_i.lp_brownout | por_i;
      set_vec_o[RSF_B_POR]     = por_i;
      set_vec_o[RSF_B_DSLP]    = pwr_i.deep_sleep;
      set_vec_o[RSF_B_SLEEP]   = pwr_i.sleep;
      set_vec_o[RSF_B_IDLE]    = pwr_i.idle;
   end
endmodule : rsf_combiner
`default_nettype wire

//--- rsf_flag_bit.sv
// One flag bit: hardware set, software write, set wins.
// Assumes synchronous power-on load of por_val_i from the parent.
`timescale 1ns/1ps
`default_nettype none
module rsf_flag_bit (
   input  wire logic clk_i,
   input  wire logic por_i,
   input  wire logic por_val_i,
   input  wire logic set_i,
   input  wire logic wr_i,
   input  wire logic wdata_i,
   output logic      q_o
);
   // ==========================================================
   // Storage
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         q_o <= por_val_i;
      end else if (set_i) begin
         q_o <= 1'b1;
      end else if (wr_i) begin
         q_o <= wdata_i;
      end
   end
endmodule : rsf_flag_bit
`default_nettype wire

//--- rsf_unit.sv
// Reset source and flag unit: master reset plus cause register.
// Assumes synchronous sources, 10 MHz clk_i, classic Wishbone master.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rsf_unit
   import rsf_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire rsf_src_t    src_i,
   input  wire rsf_pwr_t    pwr_i,
   input  wire logic        watchdog_config_fuse_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             master_system_reset_o,
   output logic             brownout_enable_o,
   output logic             watchdog_enable_o,
   output logic             progmem_sleep_power_o
);
   // ==========================================================
   // Signals
   logic        any_reset;
   logic [15:0] set_vec;
   logic [15:0] rcc;
   logic        req;
   logic        hit;
   logic [15:0] wmask;
   logic [15:0] wr_bit;

   // rst_i is the power-on reset of this unit
   rsf_combiner u_comb (
      .por_i       (rst_i),
      .src_i       (src_i),
      .pwr_i       (pwr_i),
      .any_reset_o (any_reset),
      .set_vec_o   (set_vec)
   );

   // ==========================================================
   // Bus decode
   assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   always_comb begin
      if (wb_adr_i == RSF_ADDR_RCC) begin
         hit = 1'b1;
      end else begin
         hit = 1'b0;
      end
   end
   assign wmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wr_bit = {16{req & wb_we_i & hit}} & wmask & RSF_RCC_IMPL;

   // ==========================================================
   // Flag and control bits, one cell each
   // Control bits have no hardware set; cells give a uniform path
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_bit
         if (RSF_RCC_IMPL[gi]) begin : g_impl
            rsf_flag_bit u_bit (
               .clk_i     (clk_i),
               .por_i     (rst_i),
               .por_val_i (RSF_RCC_RESET[gi]),
               .set_i     (set_vec[gi]),
               .wr_i      (wr_bit[gi]),
               .wdata_i   (wb_dat_i[gi]),
               .q_o       (rcc[gi])
            );
         end else begin : g_rsvd
            assign rcc[gi] = 1'b0;
         end
      end
   endgenerate

   // ==========================================================
   // Bus answer: one registered ack a cycle after the request, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req & ~wb_we_i & hit) begin
         wb_dat_o <= {16'h0000, rcc};
      end else if (req) begin
         wb_dat_o <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // Master reset, registered so it is glitch free
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         master_system_reset_o <= 1'b1;
      end else begin
         master_system_reset_o <= any_reset;
      end
   end

   // ==========================================================
   // Control outputs; software flag writes never feed master reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         brownout_enable_o     <= 1'b0;
         watchdog_enable_o     <= 1'b0;
         progmem_sleep_power_o <= 1'b0;
      end else begin
         brownout_enable_o     <= rcc[RSF_B_SBOR];
         watchdog_enable_o     <= rcc[RSF_B_SWDT] | watchdog_config_fuse_i;
         progmem_sleep_power_o <= rcc[RSF_B_PROGMEM_SLEEP_POWER];
      end
   end
endmodule : rsf_unit
`default_nettype wire

//--- rsf_unit_props.sv
// Port checker for rsf_unit.
// Assumes a bind from the bench; one clock, rst_i synchronous.
`timescale 1ns/1ps
`default_nettype none
module rsf_unit_props
   import rsf_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire rsf_src_t    src_i,
   input wire logic        watchdog_config_fuse_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        master_system_reset_o,
   input wire logic        brownout_enable_o,
   input wire logic        watchdog_enable_o,
   input wire logic        progmem_sleep_power_o
);
   // ==========================================
   // Properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic rd = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
   property p_rst_on; |src_i |-> ##[1:2] master_system_reset_o; endproperty
   a_rst_on: assert property (p_rst_on) else $error("master reset not raised");
   property p_rst_off; (!(|src_i)) [*3] |-> !master_system_reset_o; endproperty
   a_rst_off: assert property (p_rst_off) else $error("master reset without source");
   property p_bor; rd |-> wb_dat_o[13] == brownout_enable_o; endproperty
   a_bor: assert property (p_bor) else $error("brownout enable mismatch");
   property p_pm; rd |-> wb_dat_o[8] == progmem_sleep_power_o; endproperty
   a_pm: assert property (p_pm) else $error("sleep power mismatch");
   property p_wdt; rd |-> watchdog_enable_o == (wb_dat_o[5] | $past(watchdog_config_fuse_i)); endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog enable mismatch");
   property p_fuse; watchdog_config_fuse_i [*2] |-> watchdog_enable_o; endproperty
   a_fuse: assert property (p_fuse) else $error("fuse did not force watchdog");
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
   property p_unimpl; rd |-> wb_dat_o[31:16] == 16'h0000 && wb_dat_o[12:11] == 2'h0; endproperty
   a_unimpl: assert property (p_unimpl) else $error("unused bits not zero");
   cover property (rd);
   cover property (|src_i ##2 master_system_reset_o);
   cover property (watchdog_config_fuse_i && watchdog_enable_o);
endmodule : rsf_unit_props
`default_nettype wire

//--- rsf_src_model.sv
// Far-side model: reset sources, power events, fuse.
// Assumes the bench asks for events on ev_i, one bit each.
`timescale 1ns/1ps
`default_nettype none
module rsf_src_model
   import rsf_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic [11:0] ev_i,
   input  wire logic        fuse_i,
   output rsf_src_t         src_o,
   output rsf_pwr_t         pwr_o,
   output logic             fuse_o
);
   // ==========================================
   // Sources change just after an edge only
   always_ff @(posedge clk_i) begin
      {src_o, pwr_o} <= ev_i;
      fuse_o <= fuse_i;
   end
endmodule : rsf_src_model
`default_nettype wire

//--- rsf_unit_tb_top.sv
// Bench for rsf_unit over classic Wishbone.
// Assumes rsf_src_model on the source side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module rsf_unit_tb_top
   import rsf_pkg::*;
;
   // ==========================================
   // Signals
   logic clk_i = 1'b0, rst_i = 1'b1, fuse = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [11:0] ev = 12'h000;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, rdat;
   logic [15:0] q;
   logic ack, msr, boe, wde, pms, fuse_w;
   rsf_src_t src;
   rsf_pwr_t pwr;
   int bad_count = 0, n_tests = 0;
   int pos [12] = '{2, 3, 10, 1, 1, 4, 6, 7, 9, 14, 14, 15};
   always #50 clk_i = ~clk_i;
   rsf_src_model i_rsf_src_model (.clk_i(clk_i), .ev_i(ev), .fuse_i(fuse), .src_o(src), .pwr_o(pwr), .fuse_o(fuse_w));
   rsf_unit i_rsf_unit (.clk_i(clk_i), .rst_i(rst_i), .src_i(src), .pwr_i(pwr), .watchdog_config_fuse_i(fuse_w),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .master_system_reset_o(msr), .brownout_enable_o(boe), .watchdog_enable_o(wde),
      .progmem_sleep_power_o(pms));
   // ==========================================
   // Tasks
   task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [3:0] s);
      @(posedge clk_i);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, 16'h0000, d};
      // No local limit; the hang guard ends a lost answer
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat[15:0];
      {cyc, stb} <= 2'b00;
   endtask : acc
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task rchk(input logic [3:0] a, input logic [15:0] e);
      acc(1'b0, a, 16'h0000, 4'hF);
      chk("reg", e, q);
   endtask : rchk
   task final_report;
      $display("checks %0d bad %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   // ==========================================
   // Tests
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(4'h0, RSF_RCC_RESET);
      for (int j = 0; j < 12; j++) begin
         acc(1'b1, 4'h0, 16'h0000, 4'h3);
         ev <= 12'h001 << j;
         repeat (4) @(posedge clk_i);
         chk("rst", {15'h0, j > 2}, {15'h0, msr});
         ev <= 12'h000;
         repeat (4) @(posedge clk_i);
         rchk(4'h0, 16'h0001 << pos[j]);
      end
      acc(1'b1, 4'h0, 16'hFFFF, 4'h3);
      rchk(4'h0, RSF_RCC_IMPL);
      chk("rst", 16'h0000, {15'h0, msr});
      chk("en", 16'h0007, {13'h0, boe, wde, pms});
      acc(1'b1, 4'h0, 16'h0000, 4'h1);
      rchk(4'h0, 16'hE700);
      chk("en", 16'h0005, {13'h0, boe, wde, pms});
      fuse <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("wdt", 16'h0001, {15'h0, wde});
      fuse <= 1'b0;
      ev <= 12'h080;
      repeat (3) @(posedge clk_i);
      rchk(4'h0, 16'hE780);
      acc(1'b1, 4'h0, 16'h0000, 4'h3);
      ev <= 12'h000;
      rchk(4'h0, 16'h0080);
      acc(1'b1, 4'h1, 16'hFFFF, 4'h3);
      rchk(4'h1, 16'h0000);
      rchk(4'h0, 16'h0080);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(4'h0, RSF_RCC_RESET);
      final_report();
   end
   // Hang guard, about fourteen times the expected run
   initial begin
      repeat (3000) @(posedge clk_i);
      bad_count++;
      final_report();
   end
endmodule : rsf_unit_tb_top
bind rsf_unit rsf_unit_props i_rsf_unit_props (.clk_i(clk_i), .rst_i(rst_i), .src_i(src_i),
   .watchdog_config_fuse_i(watchdog_config_fuse_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .master_system_reset_o(master_system_reset_o),
   .brownout_enable_o(brownout_enable_o), .watchdog_enable_o(watchdog_enable_o),
   .progmem_sleep_power_o(progmem_sleep_power_o));
`default_nettype wire
